// *** rtl/sbs_bus_ctrl.sv ***
// Purpose: Bus controller that drives the SRAM module pins on orders from Avalon-MM registers.
// Assumes: Software keeps the burst order bit constant once accesses have begun.
// Notes: One issue cycle per command, and reads add a fetch cycle; a read result lands in the read registers.
`timescale 1ns/1ps
module sbs_bus_ctrl
    import sbs_pkg::*;
    #(parameter int ADDR_W = SBS_ADDR_W)
    (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    sbs_link_if.host         link
    );

    typedef enum logic [1:0] {SBS_IDLE, SBS_ISSUE, SBS_FETCH} sbs_state_t;

    initial
    begin
        if (ADDR_W < SBS_BEAT_W || ADDR_W > 32)
        begin
            $error("sbs_bus_ctrl: ADDR_W out of range");
        end
    end

    sbs_state_t            state_q;
    sbs_state_t            state_d;
    logic [31:0]           ctrl_q;
    logic [31:0]           ctrl_d;
    logic [31:0]           addr_q;
    logic [31:0]           addr_d;
    logic [SBS_DATA_W-1:0] wdata_q;
    logic [SBS_DATA_W-1:0] wdata_d;
    logic [SBS_LANES-1:0]  wpar_q;
    logic [SBS_LANES-1:0]  wpar_d;
    logic [SBS_DATA_W-1:0] rdata_q;
    logic [SBS_DATA_W-1:0] rdata_d;
    logic [SBS_LANES-1:0]  rpar_q;
    logic [SBS_LANES-1:0]  rpar_d;
    logic [31:0]           rd_q;
    logic [31:0]           rd_d;
    logic                  rd_ack_q;
    logic                  rd_ack_d;
    logic                  start;
    sbs_cmd_t              cmd;
    logic                  is_wr;

    assign cmd             = sbs_cmd_t'(ctrl_q[SBS_CTL_CMD +: 2]);
    assign is_wr           = ctrl_q[SBS_CTL_WRITE] && cmd != SBS_CMD_PROC_STROBE && cmd != SBS_CMD_DESELECT;
    // A command write waits while one is in flight; reads take one wait cycle.
    assign avs_waitrequest = (avs_read && !rd_ack_q) ||
                             (avs_write && avs_address == SBS_REG_CTRL && state_q != SBS_IDLE);
    assign start           = avs_write && !avs_waitrequest && avs_address == SBS_REG_CTRL;
    assign avs_readdata    = rd_q;

    always_comb
    begin
        state_d  = state_q;
        ctrl_d   = ctrl_q;
        addr_d   = addr_q;
        wdata_d  = wdata_q;
        wpar_d   = wpar_q;
        rdata_d  = rdata_q;
        rpar_d   = rpar_q;
        rd_ack_d = avs_read && !rd_ack_q;
        rd_d     = rd_q;
        if (avs_write && !avs_waitrequest)
        begin
            if (avs_address == SBS_REG_CTRL)
            begin
                ctrl_d = avs_writedata;
            end
            else if (avs_address == SBS_REG_ADDR)
            begin
                addr_d = avs_writedata;
            end
            else if (avs_address == SBS_REG_WLO)
            begin
                wdata_d[31:0] = avs_writedata;
            end
            else if (avs_address == SBS_REG_WHI)
            begin
                wdata_d[63:32] = avs_writedata;
            end
            else if (avs_address == SBS_REG_WPAR)
            begin
                wpar_d = avs_writedata[SBS_LANES-1:0];
            end
        end
        if (rd_ack_d)
        begin
            if (avs_address == SBS_REG_CTRL)
            begin
                rd_d = ctrl_q;
            end
            else if (avs_address == SBS_REG_ADDR)
            begin
                rd_d = addr_q;
            end
            else if (avs_address == SBS_REG_RLO)
            begin
                rd_d = rdata_q[31:0];
            end
            else if (avs_address == SBS_REG_RHI)
            begin
                rd_d = rdata_q[63:32];
            end
            else if (avs_address == SBS_REG_STAT)
            begin
                rd_d = {16'h0000, link.presence_code_bits, 3'h0, state_q != SBS_IDLE, rpar_q};
            end
            else
            begin
                rd_d = 32'h0000_0000;
            end
        end
        case (state_q)
            SBS_IDLE:
            begin
                if (start)
                begin
                    state_d = SBS_ISSUE;
                end
            end
            SBS_ISSUE:
            begin
                state_d = is_wr || cmd == SBS_CMD_DESELECT ? SBS_IDLE : SBS_FETCH;
            end
            default:
            begin
                rdata_d = link.data_lines;
                rpar_d  = link.lane_parity_bits;
                state_d = SBS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_q  <= SBS_IDLE;
            ctrl_q   <= SBS_CTRL_RESET;
            addr_q   <= '0;
            wdata_q  <= '0;
            wpar_q   <= '0;
            rdata_q  <= '0;
            rpar_q   <= '0;
            rd_q     <= '0;
            rd_ack_q <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            ctrl_q   <= ctrl_d;
            addr_q   <= addr_d;
            wdata_q  <= wdata_d;
            wpar_q   <= wpar_d;
            rdata_q  <= rdata_d;
            rpar_q   <= rpar_d;
            rd_q     <= rd_d;
            rd_ack_q <= rd_ack_d;
        end
    end

    // Strobes, write gates and the host data drive follow the held command during the single issue cycle; outside it they rest inactive.
    always_comb
    begin
        link.addr                        = addr_q[ADDR_W-1:0];
        link.controller_address_strobe_n = !(state_q == SBS_ISSUE &&
                                             (cmd == SBS_CMD_CTRL_STROBE || cmd == SBS_CMD_DESELECT));
        link.processor_address_strobe_n  = !(state_q == SBS_ISSUE && cmd == SBS_CMD_PROC_STROBE);
        link.burst_step_n                = !(state_q == SBS_ISSUE && cmd == SBS_CMD_STEP);
        link.whole_word_write_n          = !(state_q == SBS_ISSUE && is_wr && ctrl_q[SBS_CTL_WHOLE]);
        link.byte_write_gate_n           = !(state_q == SBS_ISSUE && is_wr);
        link.lane_write_enable_n         = ~ctrl_q[SBS_CTL_LANES +: SBS_LANES];
        // A deselect command drops the depth select while it is held, so its strobe loads the module inactive.
        link.chip_enable_n               = 1'b0;
        link.depth_select                = cmd != SBS_CMD_DESELECT;
        link.depth_select_n              = 1'b0;
        link.output_enable_n             = state_q != SBS_FETCH;
        link.burst_order_out             = 1'b0;
        link.burst_order_oe_n            = !ctrl_q[SBS_CTL_LINEAR];
        link.host_data_out               = wdata_q;
        link.host_par_out                = wpar_q;
        link.host_data_oe_n              = !(state_q == SBS_ISSUE && is_wr);
    end

endmodule

// *** rtl/sbs_pkg.sv ***
// Purpose: Shared constants and types for the burst SRAM module port and its controller.
// Assumes: One clock, clk_sys at 125 MHz, for both ends.
// Notes: Controller register offsets are byte addresses on a 32-bit Avalon-MM bus.
package sbs_pkg;
    localparam int          SBS_LANES       = 8;
    localparam int          SBS_LANE_W      = 8;
    localparam int          SBS_DATA_W      = SBS_LANES * SBS_LANE_W;
    localparam int          SBS_ADDR_W      = 15;
    localparam int          SBS_ADDR_W_BIG  = 16;
    localparam int          SBS_BEAT_W      = 2;
    localparam int          SBS_PRES_W      = 4;
    localparam int          SBS_PRES_SYNC   = 2;
    localparam int          SBS_PRES_DEPTH  = 0;
    localparam logic [4:0]  SBS_REG_CTRL    = 5'h00;
    localparam logic [4:0]  SBS_REG_ADDR    = 5'h04;
    localparam logic [4:0]  SBS_REG_WLO     = 5'h08;
    localparam logic [4:0]  SBS_REG_WHI     = 5'h0c;
    localparam logic [4:0]  SBS_REG_WPAR    = 5'h10;
    localparam logic [4:0]  SBS_REG_RLO     = 5'h14;
    localparam logic [4:0]  SBS_REG_RHI     = 5'h18;
    localparam logic [4:0]  SBS_REG_STAT    = 5'h1c;
    localparam int          SBS_CTL_CMD     = 0;
    localparam int          SBS_CTL_WRITE   = 2;
    localparam int          SBS_CTL_WHOLE   = 3;
    localparam int          SBS_CTL_LANES   = 4;
    localparam int          SBS_CTL_LINEAR  = 12;
    localparam int          SBS_ST_BUSY     = 8;
    localparam int          SBS_ST_PRES     = 12;
    localparam logic [31:0] SBS_CTRL_RESET  = 32'h0000_0000;

    typedef enum logic [1:0] {
        SBS_CMD_CTRL_STROBE,
        SBS_CMD_PROC_STROBE,
        SBS_CMD_STEP,
        SBS_CMD_DESELECT
    } sbs_cmd_t;
endpackage

// *** rtl/sbs_link_if.sv ***
// Purpose: Pin bundle between the SRAM module port and its bus controller.
// Assumes: Both ends run on the same clock.
// Notes: Shared pins are resolved here from the output enables; released order and presence pins read high, released data lines do not.
`timescale 1ns/1ps
interface sbs_link_if
    import sbs_pkg::*;
    #(parameter int ADDR_W = SBS_ADDR_W);
    logic [ADDR_W-1:0]     addr;
    logic                  controller_address_strobe_n;
    logic                  processor_address_strobe_n;
    logic                  burst_step_n;
    logic                  byte_write_gate_n;
    logic [SBS_LANES-1:0]  lane_write_enable_n;
    logic                  whole_word_write_n;
    logic                  chip_enable_n;
    logic                  depth_select;
    logic                  depth_select_n;
    logic                  output_enable_n;
    logic                  burst_order_out;
    logic                  burst_order_oe_n;
    logic                  burst_order;
    logic [SBS_DATA_W-1:0] host_data_out;
    logic [SBS_LANES-1:0]  host_par_out;
    logic                  host_data_oe_n;
    logic [SBS_DATA_W-1:0] dev_data_out;
    logic [SBS_LANES-1:0]  dev_par_out;
    logic                  dev_data_oe_n;
    logic [SBS_DATA_W-1:0] data_lines;
    logic [SBS_LANES-1:0]  lane_parity_bits;
    logic [SBS_PRES_W-1:0] presence_code_out;
    logic [SBS_PRES_W-1:0] presence_code_oe_n;
    logic [SBS_PRES_W-1:0] presence_code_bits;

    // The select pin has a pull-up, so a released pin means interleaved order.
    assign burst_order        = burst_order_oe_n ? 1'b1 : burst_order_out;
    // Data lines have no pull, so a bus that nobody drives reads as the inverse of the host's last value.
    assign data_lines         = !dev_data_oe_n ? dev_data_out :
                                (!host_data_oe_n ? host_data_out : ~host_data_out);
    assign lane_parity_bits   = !dev_data_oe_n ? dev_par_out :
                                (!host_data_oe_n ? host_par_out : ~host_par_out);
    assign presence_code_bits = presence_code_out | presence_code_oe_n;

    modport dev (
        input  addr, controller_address_strobe_n, processor_address_strobe_n, burst_step_n,
        input  byte_write_gate_n, lane_write_enable_n, whole_word_write_n, chip_enable_n,
        input  depth_select, depth_select_n, output_enable_n, burst_order, data_lines, lane_parity_bits,
        output dev_data_out, dev_par_out, dev_data_oe_n, presence_code_out, presence_code_oe_n
    );
    modport host (
        output addr, controller_address_strobe_n, processor_address_strobe_n, burst_step_n,
        output byte_write_gate_n, lane_write_enable_n, whole_word_write_n, chip_enable_n,
        output depth_select, depth_select_n, output_enable_n, burst_order_out, burst_order_oe_n,
        output host_data_out, host_par_out, host_data_oe_n,
        input  data_lines, lane_parity_bits, presence_code_bits
    );
endinterface

// *** rtl/sbs_module_port.sv ***
// Purpose: Synchronous pipelined burst SRAM module, 72 bits wide, as seen at its pins.
// Assumes: All pins but output_enable_n are sampled on the rising edge of clk_sys; the controller keeps its own rules.
// Notes: Storage is flip-flops, so shrink ADDR_W for quick simulation.
`timescale 1ns/1ps
module sbs_module_port
    import sbs_pkg::*;
    #(parameter int ADDR_W = SBS_ADDR_W)
    (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    sbs_link_if.dev   link
    );

    localparam int DEPTH = 1 << ADDR_W;

    initial
    begin
        if (ADDR_W < SBS_BEAT_W || ADDR_W > SBS_ADDR_W_BIG)
        begin
            $error("sbs_module_port: ADDR_W out of range");
        end
    end

    // Lane n holds data bits 8n..8n+7 and parity bit n.
    function automatic logic [SBS_LANE_W-1:0] lane_of(input logic [SBS_DATA_W-1:0] d, input int n);
        lane_of = d[n*SBS_LANE_W +: SBS_LANE_W];
    endfunction

    function automatic logic [SBS_BEAT_W-1:0] beat_addr(input logic [SBS_BEAT_W-1:0] start,
                                                        input logic [SBS_BEAT_W-1:0] cnt,
                                                        input logic                  interleave);
        if (interleave)
        begin
            beat_addr = start ^ cnt;
        end
        else
        begin
            beat_addr = start + cnt;
        end
    endfunction

    logic [SBS_LANE_W-1:0] mem_q [DEPTH][SBS_LANES];
    logic                  par_q [DEPTH][SBS_LANES];

    logic                  active_q;
    logic                  active_d;
    logic                  rd_only_q;
    logic                  rd_only_d;
    logic [ADDR_W-1:0]     base_q;
    logic [ADDR_W-1:0]     base_d;
    logic [SBS_BEAT_W-1:0] cnt_q;
    logic [SBS_BEAT_W-1:0] cnt_d;
    logic [SBS_DATA_W-1:0] rd_data_q;
    logic [SBS_DATA_W-1:0] rd_data_d;
    logic [SBS_LANES-1:0]  rd_par_q;
    logic [SBS_LANES-1:0]  rd_par_d;
    logic                  rd_valid_q;
    logic                  rd_valid_d;

    logic                  load;
    logic                  enabled;
    logic                  access;
    logic [ADDR_W-1:0]     acc_addr;
    logic [SBS_LANES-1:0]  wr_lanes;

    always_comb
    begin
        // A processor strobe counts only while the primary chip enable is low.
        load      = !link.controller_address_strobe_n ||
                    (!link.processor_address_strobe_n && !link.chip_enable_n);
        // Enables are looked at only when a new address is loaded.
        enabled   = !link.chip_enable_n && link.depth_select && !link.depth_select_n;
        active_d  = active_q;
        rd_only_d = rd_only_q;
        base_d    = base_q;
        cnt_d     = cnt_q;
        if (load)
        begin
            active_d  = enabled;
            rd_only_d = link.controller_address_strobe_n;
            base_d    = link.addr;
            cnt_d     = '0;
        end
        else if (active_q && !link.burst_step_n)
        begin
            cnt_d     = cnt_q + 1'b1;
            rd_only_d = 1'b0;
        end
        access   = load ? enabled : active_q;
        acc_addr = {base_d[ADDR_W-1:SBS_BEAT_W],
                    beat_addr(base_d[SBS_BEAT_W-1:0], cnt_d, link.burst_order)};
        if (!access || rd_only_d)
        begin
            wr_lanes = '0;
        end
        else if (!link.whole_word_write_n)
        begin
            wr_lanes = '1;
        end
        else if (!link.byte_write_gate_n)
        begin
            wr_lanes = ~link.lane_write_enable_n;
        end
        else
        begin
            wr_lanes = '0;
        end
        rd_valid_d = access && (wr_lanes == '0);
        rd_data_d  = rd_data_q;
        rd_par_d   = rd_par_q;
        if (rd_valid_d)
        begin
            for (int n = 0; n < SBS_LANES; n++)
            begin
                rd_data_d[n*SBS_LANE_W +: SBS_LANE_W] = mem_q[acc_addr][n];
                rd_par_d[n] = par_q[acc_addr][n];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            active_q   <= 1'b0;
            rd_only_q  <= 1'b0;
            base_q     <= '0;
            cnt_q      <= '0;
            rd_data_q  <= '0;
            rd_par_q   <= '0;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            active_q   <= active_d;
            rd_only_q  <= rd_only_d;
            base_q     <= base_d;
            cnt_q      <= cnt_d;
            rd_data_q  <= rd_data_d;
            rd_par_q   <= rd_par_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    // Write data is taken on the same edge that registers the write.
    always_ff @(posedge clk_sys)
    begin
        for (int n = 0; n < SBS_LANES; n++)
        begin
            if (wr_lanes[n])
            begin
                mem_q[acc_addr][n] <= lane_of(link.data_lines, n);
                par_q[acc_addr][n] <= link.lane_parity_bits[n];
            end
        end
    end

    assign link.dev_data_out  = rd_data_q;
    assign link.dev_par_out   = rd_par_q;
    // Output enable is asynchronous on the real part; here it only gates the drivers.
    assign link.dev_data_oe_n = !(rd_valid_q && !link.output_enable_n);

    // Grounded presence pins are driven low; open ones are released.
    assign link.presence_code_out  = '0;
    assign link.presence_code_oe_n = ~{1'b0, 1'b1, 1'b0, ADDR_W == SBS_ADDR_W_BIG};

endmodule

// *** testbench/sbs_link_props.sv ***
// Purpose: Concurrent checks on the pins between the SRAM module port and its controller.
// Assumes: One clock; rst_n is synchronous and active low.
// Notes: Only the pin bundle is seen here, so register-side timing is judged by the bench.
`timescale 1ns/1ps
module sbs_link_props
    import sbs_pkg::*;
    #(parameter int ADDR_W = SBS_ADDR_W)
    (
    input wire logic                  clk_sys,
    input wire logic                  rst_n,
    input wire logic                  controller_address_strobe_n,
    input wire logic                  processor_address_strobe_n,
    input wire logic                  byte_write_gate_n,
    input wire logic                  whole_word_write_n,
    input wire logic                  chip_enable_n,
    input wire logic                  depth_select,
    input wire logic                  depth_select_n,
    input wire logic                  output_enable_n,
    input wire logic                  burst_order,
    input wire logic                  host_data_oe_n,
    input wire logic                  dev_data_oe_n,
    input wire logic [SBS_PRES_W-1:0] presence_code_bits
    );
    localparam logic [SBS_PRES_W-1:0] PRES_EXP = {1'b1, 1'b0, 1'b1, (ADDR_W == SBS_ADDR_W_BIG) ? 1'b0 : 1'b1};
    logic sel_all;
    logic load;
    logic seen_d;
    logic seen_q;
    always_comb
    begin
        sel_all = !chip_enable_n && depth_select && !depth_select_n;
        load    = !controller_address_strobe_n || (!processor_address_strobe_n && !chip_enable_n);
        seen_d  = seen_q || load;
    end
    // Order changes are legal only before the first load after reset.
    always_ff @(posedge clk_sys)
    begin
        seen_q <= rst_n ? seen_d : 1'b0;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    property p_presence;
        presence_code_bits == PRES_EXP;
    endproperty
    a_presence: assert property (p_presence) else $error("presence code wrong");
    property p_order_fixed;
        seen_q |-> $stable(burst_order);
    endproperty
    a_order_fixed: assert property (p_order_fixed) else $error("burst order moved");
    property p_order_default;
        (!seen_q && !load) |-> burst_order;
    endproperty
    a_order_default: assert property (p_order_default) else $error("select not released");
    property p_read_answer;
        (!controller_address_strobe_n && byte_write_gate_n && whole_word_write_n && sel_all)
            |=> (!output_enable_n && !dev_data_oe_n);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_write_quiet;
        (!controller_address_strobe_n && !byte_write_gate_n) |=> dev_data_oe_n;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("device drove after write");
    property p_write_data;
        (!controller_address_strobe_n && !byte_write_gate_n) |-> !host_data_oe_n;
    endproperty
    a_write_data: assert property (p_write_data) else $error("write data not driven");
    property p_whole_data;
        (!controller_address_strobe_n && !whole_word_write_n) |-> !host_data_oe_n;
    endproperty
    a_whole_data: assert property (p_whole_data) else $error("whole write data missing");
    property p_deselect;
        (!controller_address_strobe_n && !sel_all) |=> dev_data_oe_n [*2];
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselected device drove");
    property p_no_fight;
        !dev_data_oe_n |-> (host_data_oe_n && !output_enable_n);
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("data lines contended");
endmodule

// *** testbench/sync_burst_sram_module_port_bench.sv ***
// Purpose: Self-checking bench for the SRAM module port and its controller, joined pin to pin.
// Assumes: A set lane bit in the control register means that lane is written.
// Notes: A small ADDR_W keeps the flip-flop storage quick; the strapping then reads small size.
`timescale 1ns/1ps
module sync_burst_sram_module_port_bench;
    import sbs_pkg::*;
    localparam int          AW     = 5;
    localparam logic [63:0] BASE_W = 64'h0123_4567_89ab_cdef;
    localparam logic [63:0] NEW_W  = 64'hfedc_ba98_7654_3210;
    localparam logic [7:0]  BASE_P = 8'h3c;
    localparam logic [7:0]  NEW_P  = 8'hc3;
    typedef struct packed { logic [7:0] lanes; logic whole; } sbs_row_t;
    logic        clk_sys;
    logic        rst_n;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        lin;
    logic [31:0] lo, hi, st;
    logic [71:0] m;
    int          err_total;
    int          num_checks;
    sbs_row_t    rows [5] = '{'{8'h01, 1'b0}, '{8'h80, 1'b0}, '{8'h5a, 1'b0}, '{8'h00, 1'b1}, '{8'h00, 1'b0}};
    sbs_link_if #(.ADDR_W(AW)) lk ();
    sbs_module_port #(.ADDR_W(AW)) sbs_module_port_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(lk));
    sbs_bus_ctrl #(.ADDR_W(AW)) sbs_bus_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(lk));
    sbs_link_props #(.ADDR_W(AW)) sbs_link_props_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .controller_address_strobe_n(lk.controller_address_strobe_n),
        .processor_address_strobe_n(lk.processor_address_strobe_n), .byte_write_gate_n(lk.byte_write_gate_n),
        .whole_word_write_n(lk.whole_word_write_n), .chip_enable_n(lk.chip_enable_n),
        .depth_select(lk.depth_select), .depth_select_n(lk.depth_select_n), .output_enable_n(lk.output_enable_n),
        .burst_order(lk.burst_order), .host_data_oe_n(lk.host_data_oe_n), .dev_data_oe_n(lk.dev_data_oe_n),
        .presence_code_bits(lk.presence_code_bits));
    function automatic logic [31:0] ctl(logic [1:0] c, logic w, logic wh, logic [7:0] ln);
        return {19'h0, lin, ln, wh, w, c};
    endfunction
    function automatic logic [31:0] word(logic [4:0] a);
        return 32'ha5a5_0000 | {27'h0, a};
    endfunction
    function automatic logic [71:0] merge(logic [7:0] ln, logic wh);
        logic [71:0] r;
        r = {BASE_P, BASE_W};
        for (int n = 0; n < 8; n++)
            if (wh || ln[n])
            begin
                r[8*n +: 8] = NEW_W[8*n +: 8];
                r[64+n]     = NEW_P[n];
            end
        return r;
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Entered just after a rising edge; the request stands until waitrequest is seen low at an edge.
    task automatic xfer(input logic [4:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        // Values read just after the edge are those that stood at it, since every flop updates by NBA.
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 100)
        begin
            @(posedge clk_sys);
            n++;
        end
        rd = avs_readdata;
        if (avs_waitrequest !== 1'b0)
            err_total++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic cmd(input logic [31:0] c);
        int          k;
        logic [31:0] s;
        k = 0;
        xfer(SBS_REG_CTRL, 1'b1, c, s);
        s[SBS_ST_BUSY] = 1'b1;
        while (s[SBS_ST_BUSY] !== 1'b0 && k < 50)
        begin
            xfer(SBS_REG_STAT, 1'b0, 32'h0, s);
            k++;
        end
        if (s[SBS_ST_BUSY] !== 1'b0)
            err_total++;
    endtask
    task automatic seta(input logic [4:0] a);
        xfer(SBS_REG_ADDR, 1'b1, {27'h0, a}, st);
    endtask
    task automatic get(input logic [31:0] c);
        cmd(c);
        xfer(SBS_REG_RLO, 1'b0, 32'h0, lo);
        xfer(SBS_REG_RHI, 1'b0, 32'h0, hi);
        xfer(SBS_REG_STAT, 1'b0, 32'h0, st);
    endtask
    task automatic put(input logic [4:0] a, input logic [63:0] d, input logic [7:0] p, input logic [7:0] ln,
                       input logic wh);
        seta(a);
        xfer(SBS_REG_WLO, 1'b1, d[31:0], st);
        xfer(SBS_REG_WHI, 1'b1, d[63:32], st);
        xfer(SBS_REG_WPAR, 1'b1, {24'h0, p}, st);
        cmd(ctl(2'd0, 1'b1, wh, ln));
    endtask
    task automatic burst(input logic [1:0] s, input int n);
        logic [1:0] b;
        seta({3'b001, s});
        get(ctl(2'd0, 1'b0, 1'b0, 8'h00));
        chk(lo, word({3'b001, s}));
        for (int i = 1; i <= n; i++)
        begin
            b = lin ? s + i[1:0] : s ^ i[1:0];
            get(ctl(2'd2, 1'b0, 1'b0, 8'h00));
            chk(lo, word({3'b001, b}));
        end
        $display("burst from beat %0d done", s);
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // The whole run needs under a thousand cycles, so this limit only trips on a hang.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        final_report();
    end
    initial
    begin
        rst_n = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        lin = 1'b0;
        err_total = 0;
        num_checks = 0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        for (int a = 0; a < 4; a++)
            put(5'(4 + a), {~word(5'(4 + a)), word(5'(4 + a))}, 8'(a), 8'h00, 1'b1);
        burst(2'd1, 3);
        burst(2'd3, 1);
        foreach (rows[r])
        begin
            put(5'd9, BASE_W, BASE_P, 8'h00, 1'b1);
            put(5'd9, NEW_W, NEW_P, rows[r].lanes, rows[r].whole);
            seta(5'd9);
            get(ctl(2'd0, 1'b0, 1'b0, 8'h00));
            m = merge(rows[r].lanes, rows[r].whole);
            chk(lo, m[31:0]);
            chk(hi, m[63:32]);
            chk({24'h0, st[7:0]}, {24'h0, m[71:64]});
            $display("lane row %0d done", r);
        end
        seta(5'd6);
        get(ctl(2'd1, 1'b1, 1'b0, 8'hff));
        chk(lo, word(5'd6));
        get(ctl(2'd0, 1'b0, 1'b0, 8'h00));
        chk(hi, ~word(5'd6));
        $display("processor strobe done");
        seta(5'd5);
        xfer(SBS_REG_CTRL, 1'b1, ctl(2'd0, 1'b0, 1'b0, 8'h00), st);
        cmd(ctl(2'd3, 1'b0, 1'b0, 8'h00));
        xfer(SBS_REG_RLO, 1'b0, 32'h0, lo);
        chk(lo, word(5'd5));
        get(ctl(2'd2, 1'b0, 1'b0, 8'h00));
        chk(lo, ~NEW_W[31:0]);
        xfer(5'h1e, 1'b0, 32'h0, lo);
        chk(lo, 32'h0);
        $display("deselect and unmapped done");
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        xfer(SBS_REG_CTRL, 1'b0, 32'h0, lo);
        chk(lo, SBS_CTRL_RESET);
        xfer(SBS_REG_STAT, 1'b0, 32'h0, st);
        chk(st & 32'h0000_f100, 32'h0000_b000);
        $display("reset done");
        lin = 1'b1;
        burst(2'd1, 3);
        burst(2'd3, 1);
        final_report();
    end
endmodule
